// ### dcca_pkg.sv
// shared constants, modes and carriers of the dual capture/compare array
package dcca_pkg;
	localparam int N_CH   = 16;
	localparam int N_SRC  = 36;
	localparam int SRC_PER_UNIT = 18;
	localparam int ADDR_W = 12;
	// per-unit register offsets; unit two sits at byte 0x100 above unit one
	localparam logic [7:0] OFF_TCTRL  = 8'h00;
	localparam logic [7:0] OFF_TVAL_A = 8'h04;
	localparam logic [7:0] OFF_RLD_A  = 8'h08;
	localparam logic [7:0] OFF_TVAL_B = 8'h0C;
	localparam logic [7:0] OFF_RLD_B  = 8'h10;
	localparam logic [7:0] OFF_TIC_A  = 8'h14;
	localparam logic [7:0] OFF_TIC_B  = 8'h18;
	localparam logic [7:0] OFF_MODE   = 8'h40;
	localparam logic [7:0] OFF_CCVAL  = 8'h80;
	localparam logic [7:0] OFF_CCIC   = 8'hC0;
	// interrupt control field positions
	localparam int IC_GRP_LSB  = 0;
	localparam int IC_PRIO_LSB = 2;
	localparam int IC_EN_BIT   = 6;
	localparam int IC_FLAG_BIT = 7;
	// reset values
	localparam logic [5:0]  RST_TCFG = 6'h00;
	localparam logic [4:0]  RST_MODE = 5'h00;
	localparam logic [15:0] RST_RLD  = 16'h0000;
	localparam logic [7:0]  RST_IC   = 8'h00;
	// smallest prescale factor is 8, i.e. two to the third
	localparam logic [10:0] PRESC_BASE = 11'h008;
	// unit two channels that never drive their pin
	localparam logic [15:0] U2_IN_ONLY = 16'h0F00;
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		CC_OFF, CAP_RISE, CAP_FALL, CAP_BOTH, CMP_M0, CMP_M1, CMP_M2, CMP_M3
	} cc_mode_e;

	typedef enum logic [1:0] {TS_PRESC, TS_NEIGH, TS_EXT, TS_STOP} tsrc_e;

	typedef struct packed {
		logic     run;
		tsrc_e    src;
		logic [2:0] input_prescale_select;
	} tmr_cfg_s;

	typedef struct packed {
		logic     dbl;
		logic     tsel;
		cc_mode_e mode;
	} ch_cfg_s;
endpackage

// ### cc_timer.sv
// one reloadable 16-bit time-base timer
`timescale 1ns/1ps
module cc_timer import dcca_pkg::*; #(
	parameter int W       = 16,
	parameter bit HAS_EXT = 1'b1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire tmr_cfg_s     cfg,
	input  wire logic [9:0]   presc,
	input  wire logic         nb_ovf,
	input  wire logic         ext_rise,
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wr_data,
	input  wire logic [W-1:0] reload,
	output logic [W-1:0]      value_q,
	output logic              upd_q,
	output logic              ovf_q
);
	logic [9:0] mask;
	logic       tick;

	always_comb begin
		mask = 10'((PRESC_BASE << cfg.input_prescale_select) - 11'h001);
		case (cfg.src)
			TS_PRESC: tick = cfg.run & ((presc & mask) == mask);
			TS_NEIGH: tick = cfg.run & nb_ovf;
			TS_EXT:   tick = cfg.run & HAS_EXT & ext_rise;
			default:  tick = 1'b0;
		endcase
	end

	// a software write to the count takes precedence over a tick in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			value_q <= '0;
			upd_q   <= 1'b0;
			ovf_q   <= 1'b0;
		end else begin
			upd_q <= tick & ~wr_en;
			ovf_q <= tick & ~wr_en & (&value_q);
			if (wr_en) begin
				value_q <= wr_data;
			end else if (tick) begin
				value_q <= (&value_q) ? reload : value_q + 1'b1;
			end
		end
	end
endmodule

// ### cc_channel.sv
// one dual-purpose capture/compare channel with its pin logic
`timescale 1ns/1ps
module cc_channel import dcca_pkg::*; #(
	parameter bit OUT_OK = 1'b1
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire ch_cfg_s     cfg,
	input  wire logic        pin_s,
	input  wire logic [15:0] tval_a,
	input  wire logic [15:0] tval_b,
	input  wire logic [1:0]  upd,
	input  wire logic [1:0]  ovf,
	input  wire logic        partner_tgl,
	input  wire logic        partner_on,
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	output logic [15:0]      cc_q,
	output logic             event_o,
	output logic             tgl_o,
	output logic             pin_q,
	output logic             pin_oe
);
	logic        prev_q;
	logic        fired_q;
	logic [15:0] tv;
	logic        t_upd;
	logic        t_ovf;
	logic        cap;
	logic        once;
	logic        match;
	logic        first;

	always_comb begin
		tv    = cfg.tsel ? tval_b : tval_a;
		t_upd = cfg.tsel ? upd[1] : upd[0];
		t_ovf = cfg.tsel ? ovf[1] : ovf[0];
		cap   = ((cfg.mode == CAP_RISE) & pin_s & ~prev_q)
			| ((cfg.mode == CAP_FALL) & ~pin_s & prev_q)
			| ((cfg.mode == CAP_BOTH) & (pin_s ^ prev_q));
		once  = (cfg.mode == CMP_M2) | (cfg.mode == CMP_M3);
		match = (cfg.mode >= CMP_M0) & t_upd & (tv == cc_q);
		// an overflow in the same update opens the new period first
		first = match & ~(once & fired_q & ~t_ovf);
	end

	assign event_o = cap | first;
	assign tgl_o   = first & cfg.dbl & (cfg.mode == CMP_M1);
	// only single-register toggle and set/reset modes own the pin, as does a partner's double toggle mode; interrupt-only modes leave it alone
	assign pin_oe  = OUT_OK & (((cfg.mode == CMP_M1) & ~cfg.dbl)
		| (cfg.mode == CMP_M3) | partner_on);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= pin_s;
		end
	end

	// a capture beats a software write landing in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cc_q <= '0;
		end else if (cap) begin
			cc_q <= tv;
		end else if (wr_en) begin
			cc_q <= wr_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fired_q <= 1'b0;
		end else begin
			fired_q <= (fired_q & ~t_ovf) | (match & once);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_q <= 1'b0;
		end else if (cfg.mode == CMP_M3) begin
			if (first) begin
				pin_q <= 1'b1;
			end else if (t_ovf) begin
				pin_q <= 1'b0;
			end
		end else begin
			pin_q <= pin_q ^ (first & (cfg.mode == CMP_M1) & ~cfg.dbl) ^ partner_tgl;
		end
	end
endmodule

// ### dual_capture_compare_array.sv
// two capture/compare units with time bases, interrupt control and register slave
//
// What this block does
// - two arrays of 16 registers, each picks its unit's timer and capture or compare
// - four 16-bit timers with reload registers, two per unit
// - timers count prescaled system clock or neighbour timer overflow
// - 3-bit prescale select divides by 8 up to 1024
// - first timer of each unit may count an external input
// - each channel owns a pin: capture trigger or compare output
// - second unit channels 8 to 11 are input only, never drive
// - capture latches allocated timer into register and sets request
// - capture edge selectable: rising, falling or both
// - compare registers checked on every timer update; match triggers mode action
// - mode 0: interrupt on every match, pin untouched
// - mode 1: pin toggles on every match
// - mode 2: interrupt only, once per timer period
// - mode 3: pin set on match, cleared on overflow, once per period
// - double register mode: two registers toggle one shared pin
// - control bits in low byte; upper byte reads zero, writes ignored
// - every control bit, request flag too, is software read/write
// - 2-bit group level orders equal priorities, 3 highest
// - 4-bit priority level, Fh highest, 0h lowest
// - enable bit gates request into arbitration
// - request flag reads 1 while pending, set by hardware event
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module dual_capture_compare_array import dcca_pkg::*; (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic [31:0]       cc_pin_in,
	output logic [31:0]            cc_pin_out,
	output logic [31:0]            cc_pin_oe,
	input  wire logic [1:0]        ext_count_in,
	input  wire logic              neighbour_block_timer_ovf,
	output logic                   irq_pending_q,
	output logic [5:0]             irq_source_q,
	output logic [3:0]             irq_priority_q,
	output logic [1:0]             irq_group_q
);
	logic [31:0]    pin_m_q;
	logic [31:0]    pin_s_q;
	logic [1:0]     ext_m_q;
	logic [1:0]     ext_s_q;
	logic [1:0]     ext_prev_q;
	logic [9:0]     presc_q;
	tmr_cfg_s       tcfg_q [4];
	logic [15:0]    rld_q [4];
	logic [15:0]    tval [4];
	logic [3:0]     t_upd;
	logic [3:0]     t_ovf;
	ch_cfg_s        mode_q [32];
	logic [15:0]    cc_val [32];
	logic [31:0]    ch_evt;
	logic [31:0]    ch_tgl;
	logic [7:0]     ic_q [N_SRC];
	logic [N_SRC-1:0] src_evt;
	logic           bvalid_q;
	logic [1:0]     bresp_q;
	logic           rvalid_q;
	logic [31:0]    rdata_q;
	logic [1:0]     rresp_q;
	logic           w_fire;
	logic           w_u;
	logic [7:0]     w_o;
	logic [32:0]    w_cur;
	logic [31:0]    w_mask;
	logic [31:0]    wm;
	logic [32:0]    r_cur;

	function automatic logic [5:0] sidx(input logic u, input logic [4:0] n);
		sidx = (u ? 6'd18 : 6'd0) + {1'b0, n};
	endfunction

	// bit 32 of the result flags a mapped address
	function automatic logic [32:0] reg_read(input logic [ADDR_W-1:0] a);
		logic       u;
		logic [7:0] o;
		logic [4:0] ch;
		u  = a[8];
		o  = a[7:0];
		ch = {u, o[5:2]};
		reg_read = {1'b1, 32'h0000_0000};
		if (a[ADDR_W-1:9] != '0) begin
			reg_read[32] = 1'b0;
		end else if (o[7:2] == OFF_TCTRL[7:2]) begin
			reg_read[15:0] = {2'b00, tcfg_q[{u, 1'b1}], 2'b00, tcfg_q[{u, 1'b0}]};
		end else if (o[7:2] == OFF_TVAL_A[7:2]) begin
			reg_read[15:0] = tval[{u, 1'b0}];
		end else if (o[7:2] == OFF_RLD_A[7:2]) begin
			reg_read[15:0] = rld_q[{u, 1'b0}];
		end else if (o[7:2] == OFF_TVAL_B[7:2]) begin
			reg_read[15:0] = tval[{u, 1'b1}];
		end else if (o[7:2] == OFF_RLD_B[7:2]) begin
			reg_read[15:0] = rld_q[{u, 1'b1}];
		end else if (o[7:2] == OFF_TIC_A[7:2]) begin
			reg_read[7:0] = ic_q[sidx(u, 5'd16)];
		end else if (o[7:2] == OFF_TIC_B[7:2]) begin
			reg_read[7:0] = ic_q[sidx(u, 5'd17)];
		end else if (o >= OFF_MODE && o < OFF_CCVAL) begin
			reg_read[4:0] = mode_q[ch];
		end else if (o >= OFF_CCVAL && o < OFF_CCIC) begin
			reg_read[15:0] = cc_val[ch];
		end else if (o >= OFF_CCIC) begin
			reg_read[7:0] = ic_q[sidx(u, {1'b0, o[5:2]})];
		end else begin
			reg_read[32] = 1'b0;
		end
	endfunction

	// pins and external count inputs come from outside the clock domain
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_m_q    <= '0;
			pin_s_q    <= '0;
			ext_m_q    <= '0;
			ext_s_q    <= '0;
			ext_prev_q <= '0;
		end else begin
			pin_m_q    <= cc_pin_in;
			pin_s_q    <= pin_m_q;
			ext_m_q    <= ext_count_in;
			ext_s_q    <= ext_m_q;
			ext_prev_q <= ext_s_q;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc_q <= '0;
		end else begin
			presc_q <= presc_q + 1'b1;
		end
	end

	// write channel: address and data are taken together, one write at a time
	assign w_fire  = awvalid & wvalid & ~bvalid_q;
	assign awready = w_fire;
	assign wready  = w_fire;
	assign w_u     = awaddr[8];
	assign w_o     = awaddr[7:0];
	// always_comb, not assign: the read also depends on register contents, not only the address
	always_comb w_cur = reg_read(awaddr);
	assign w_mask  = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
	assign wm      = (w_cur[31:0] & ~w_mask) | (wdata & w_mask);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (w_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= w_cur[32] ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign arready = ~rvalid_q;
	always_comb r_cur = reg_read(araddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end else if (arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q  <= r_cur[31:0];
			rresp_q  <= r_cur[32] ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign rvalid = rvalid_q;
	assign rdata  = rdata_q;
	assign rresp  = rresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 4; i++) begin
				tcfg_q[i] <= RST_TCFG;
				rld_q[i]  <= RST_RLD;
			end
		end else if (w_fire && w_cur[32]) begin
			if (w_o[7:2] == OFF_TCTRL[7:2]) begin
				tcfg_q[{w_u, 1'b0}] <= wm[5:0];
				tcfg_q[{w_u, 1'b1}] <= wm[13:8];
			end else if (w_o[7:2] == OFF_RLD_A[7:2]) begin
				rld_q[{w_u, 1'b0}] <= wm[15:0];
			end else if (w_o[7:2] == OFF_RLD_B[7:2]) begin
				rld_q[{w_u, 1'b1}] <= wm[15:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 32; i++) begin
				mode_q[i] <= RST_MODE;
			end
		end else if (w_fire && w_cur[32] && w_o >= OFF_MODE && w_o < OFF_CCVAL) begin
			mode_q[{w_u, w_o[5:2]}] <= wm[4:0];
		end
	end

	// a hardware event in the same cycle as a software clear keeps the flag set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < N_SRC; i++) begin
				ic_q[i] <= RST_IC;
			end
		end else begin
			for (int i = 0; i < N_SRC; i++) begin
				if (w_fire && w_cur[32] && ((w_o >= OFF_CCIC && sidx(w_u, {1'b0, w_o[5:2]}) == i)
					|| (w_o[7:2] == OFF_TIC_A[7:2] && sidx(w_u, 5'd16) == i)
					|| (w_o[7:2] == OFF_TIC_B[7:2] && sidx(w_u, 5'd17) == i))) begin
					ic_q[i] <= {wm[IC_FLAG_BIT] | src_evt[i], wm[6:0]};
				end else if (src_evt[i]) begin
					ic_q[i][IC_FLAG_BIT] <= 1'b1;
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_tmr
			cc_timer #(
				.W      (16),
				.HAS_EXT(g % 2 == 0)
			) u_tmr (
				.aclk    (aclk),
				.aresetn (aresetn),
				.cfg     (tcfg_q[g]),
				.presc   (presc_q),
				.nb_ovf  (neighbour_block_timer_ovf),
				.ext_rise(ext_s_q[g/2] & ~ext_prev_q[g/2]),
				.wr_en   (w_fire && w_cur[32] && w_u == 1'(g / 2)
					&& w_o[7:2] == ((g % 2 == 1) ? OFF_TVAL_B[7:2] : OFF_TVAL_A[7:2])),
				.wr_data (wm[15:0]),
				.reload  (rld_q[g]),
				.value_q (tval[g]),
				.upd_q   (t_upd[g]),
				.ovf_q   (t_ovf[g])
			);
		end
		for (g = 0; g < 32; g++) begin : g_ch
			localparam int U = g / 16;
			localparam int C = g % 16;
			cc_channel #(
				.OUT_OK(!(U == 1 && U2_IN_ONLY[C]))
			) u_ch (
				.aclk       (aclk),
				.aresetn    (aresetn),
				.cfg        (mode_q[g]),
				.pin_s      (pin_s_q[g]),
				.tval_a     (tval[2*U]),
				.tval_b     (tval[2*U+1]),
				.upd        (t_upd[2*U+1 -: 2]),
				.ovf        (t_ovf[2*U+1 -: 2]),
				.partner_tgl((C < 8) ? ch_tgl[(g+8)%32] : 1'b0),
				.partner_on ((C < 8) ? (mode_q[(g+8)%32].dbl
					&& mode_q[(g+8)%32].mode == CMP_M1) : 1'b0),
				.wr_en      (w_fire && w_cur[32] && {w_u, w_o[5:2]} == g
					&& w_o >= OFF_CCVAL && w_o < OFF_CCIC),
				.wr_data    (wm[15:0]),
				.cc_q       (cc_val[g]),
				.event_o    (ch_evt[g]),
				.tgl_o      (ch_tgl[g]),
				.pin_q      (cc_pin_out[g]),
				.pin_oe     (cc_pin_oe[g])
			);
		end
	endgenerate

	always_comb begin
		src_evt = '0;
		src_evt[15:0]  = ch_evt[15:0];
		src_evt[16]    = t_ovf[0];
		src_evt[17]    = t_ovf[1];
		src_evt[33:18] = ch_evt[31:16];
		src_evt[34]    = t_ovf[2];
		src_evt[35]    = t_ovf[3];
	end

	// pick the pending, enabled source with the highest priority then group level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_pending_q  <= 1'b0;
			irq_source_q   <= '0;
			irq_priority_q <= '0;
			irq_group_q    <= '0;
		end else begin
			logic       hit;
			logic [5:0] best;
			logic [5:0] key;
			hit  = 1'b0;
			best = '0;
			key  = '0;
			for (int i = 0; i < N_SRC; i++) begin
				if (ic_q[i][IC_FLAG_BIT] && ic_q[i][IC_EN_BIT]
					&& (!hit || ic_q[i][5:0] > key)) begin
					hit  = 1'b1;
					best = 6'(i);
					key  = ic_q[i][5:0];
				end
			end
			irq_pending_q  <= hit;
			irq_source_q   <= best;
			irq_priority_q <= key[IC_PRIO_LSB +: 4];
			irq_group_q    <= key[IC_GRP_LSB +: 2];
		end
	end
endmodule

// ### pin_side_model.sv
// far side of the channel pins: external levels with read-back of driven pins
`timescale 1ns/1ps
module pin_side_model import dcca_pkg::*; (
	input  wire logic [31:0] cc_pin_out,
	input  wire logic [31:0] cc_pin_oe,
	input  wire logic [31:0] drive_lvl,
	output logic [31:0]      cc_pin_in
);
	// a pin the block drives reads back its own level, others follow the outside source
	always_comb cc_pin_in = (cc_pin_oe & cc_pin_out) | (~cc_pin_oe & drive_lvl);
endmodule

// ### dcca_chk.sv
// concurrent checks on the register bus, reads and pin enables
`timescale 1ns/1ps
module dcca_chk import dcca_pkg::*; (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic              awvalid,
	input wire logic              awready,
	input wire logic              wvalid,
	input wire logic              wready,
	input wire logic [1:0]        bresp,
	input wire logic              bvalid,
	input wire logic              bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic              arvalid,
	input wire logic              arready,
	input wire logic [31:0]       rdata,
	input wire logic [1:0]        rresp,
	input wire logic              rvalid,
	input wire logic              rready,
	input wire logic [31:0]       cc_pin_oe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_take;
		awvalid && wvalid && awready;
	endsequence
	sequence s_rd_take;
		arvalid && arready;
	endsequence
	property p_wr_answer;
		s_wr_take |=> bvalid;
	endproperty
	property p_wr_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	property p_wr_block;
		bvalid |-> !awready && !wready;
	endproperty
	property p_wr_slverr;
		s_wr_take ##0 (awaddr[ADDR_W-1:9] != 3'h0) |=> bresp == RESP_SLVERR;
	endproperty
	property p_rd_answer;
		s_rd_take |=> rvalid;
	endproperty
	property p_rd_hold;
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
	endproperty
	property p_rd_slverr;
		s_rd_take ##0 (araddr[ADDR_W-1:9] != 3'h0) |=> rresp == RESP_SLVERR && rdata == 32'h0;
	endproperty
	property p_ic_upper;
		s_rd_take ##0 (araddr[7:6] == 2'b11) |=> rdata[31:8] == 24'h00_0000;
	endproperty
	property p_in_only;
		cc_pin_oe[27:24] == 4'h0;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
	a_wr_hold: assert property (p_wr_hold) else $error("write response dropped");
	a_wr_block: assert property (p_wr_block) else $error("write taken while busy");
	a_wr_slverr: assert property (p_wr_slverr) else $error("unmapped write okay");
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
	a_rd_slverr: assert property (p_rd_slverr) else $error("unmapped read okay");
	a_ic_upper: assert property (p_ic_upper) else $error("control upper bits set");
	a_in_only: assert property (p_in_only) else $error("input only pin driven");
endmodule
bind dual_capture_compare_array dcca_chk u_chk (.aclk(aclk), .aresetn(aresetn),
	.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
	.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
	.cc_pin_oe(cc_pin_oe));

// ### testbench.sv
// self-checking bench for the dual capture/compare array
`timescale 1ns/1ps
module testbench import dcca_pkg::*; ;
	logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready, nb_ovf, irq_pending_q;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata, pin_in, pin_out, pin_oe, pin_lvl, d;
	logic [3:0]        wstrb, irq_priority_q;
	logic [1:0]        bresp, rresp, ext_in, irq_group_q, resp;
	logic [5:0]        irq_source_q;
	int                err_count, total_checks;

	dual_capture_compare_array DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .cc_pin_in(pin_in), .cc_pin_out(pin_out), .cc_pin_oe(pin_oe),
		.ext_count_in(ext_in), .neighbour_block_timer_ovf(nb_ovf),
		.irq_pending_q(irq_pending_q), .irq_source_q(irq_source_q),
		.irq_priority_q(irq_priority_q), .irq_group_q(irq_group_q));
	pin_side_model u_pins (.cc_pin_out(pin_out), .cc_pin_oe(pin_oe), .drive_lvl(pin_lvl),
		.cc_pin_in(pin_in));

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	function automatic logic [11:0] ca(input logic [7:0] off, input bit u, input int c);
		return {3'b000, u, off} + 12'(4 * c);
	endfunction

	task automatic end_sim();
		if (err_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic tmo(input int n);
		if (n >= 99) begin
			cmp("handshake", 32'h0000_0001, 32'h0000_0000);
			end_sim();
		end
	endtask

	// ready rises only once the answer is seen, so the slave must hold it for a cycle
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin @(negedge aclk); n++; end while (awready !== 1'b1 && n < 50);
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do begin @(negedge aclk); n++; end while (bvalid !== 1'b1 && n < 99);
		resp = bresp;
		@(posedge aclk);
		bready <= 1'b1;
		@(posedge aclk);
		bready <= 1'b0;
		tmo(n);
	endtask

	task automatic rd(input logic [11:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin @(negedge aclk); n++; end while (arready !== 1'b1 && n < 50);
		@(posedge aclk);
		arvalid <= 1'b0;
		do begin @(negedge aclk); n++; end while (rvalid !== 1'b1 && n < 99);
		d = rdata;
		resp = rresp;
		@(posedge aclk);
		rready <= 1'b1;
		@(posedge aclk);
		rready <= 1'b0;
		tmo(n);
	endtask

	task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
		rd(a);
		cmp(nm, e, d);
	endtask

	// the arbitration outputs are registered, so allow them a few cycles to settle
	task automatic irq(input logic [12:0] e);
		logic [12:0] cur;
		int n;
		n = 0;
		do begin
			@(negedge aclk);
			cur = {irq_pending_q, irq_source_q, irq_priority_q, irq_group_q};
			n++;
		end while (cur !== e && n < 8);
		@(posedge aclk);
		cmp("irq", 32'(e), 32'(e[12] ? cur : {cur[12], 12'h000}));
	endtask

	task automatic tick(input int n);
		repeat (n) begin
			nb_ovf <= 1'b1;
			@(posedge aclk);
			nb_ovf <= 1'b0;
			repeat (4) @(posedge aclk);
		end
	endtask

	initial begin
		{aresetn, awvalid, wvalid, arvalid, nb_ovf} = '0;
		{bready, rready, wstrb} = 6'h0F;
		{awaddr, araddr, wdata, pin_lvl, ext_in, err_count, total_checks} = '0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc("mode", ca(OFF_MODE, 0, 0), 32'h0000_0000);
		wr(ca(OFF_CCIC, 0, 3), 32'hFFFF_FFFF);
		rc("ic", ca(OFF_CCIC, 0, 3), 32'h0000_00FF);
		irq({1'b1, 6'd3, 4'hF, 2'd3});
		wr(ca(OFF_CCIC, 0, 3), 32'h0000_00BF);
		irq(13'h0000);
		wr(ca(OFF_CCIC, 0, 3), 32'h0000_00C4);
		irq({1'b1, 6'd3, 4'h1, 2'd0});
		wr(ca(OFF_CCIC, 0, 5), 32'h0000_00C7);
		irq({1'b1, 6'd5, 4'h1, 2'd3});
		wr(ca(OFF_CCIC, 0, 6), 32'h0000_00C8);
		irq({1'b1, 6'd6, 4'h2, 2'd0});
		for (int i = 3; i <= 6; i++) wr(ca(OFF_CCIC, 0, i), 32'h0000_0000);
		irq(13'h0000);
		wr(12'h020, 32'h0000_0001);
		cmp("bresp", 32'(RESP_SLVERR), 32'(resp));
		wr(12'h400, 32'h0000_0001);
		cmp("bresp_hi", 32'(RESP_SLVERR), 32'(resp));
		rc("unmapped", 12'h200, 32'h0000_0000);
		cmp("rresp", 32'(RESP_SLVERR), 32'(resp));
		for (int m = 1; m <= 3; m++) begin
			wr(ca(OFF_MODE, 1, 1), 32'(m + 8));
			wr(ca(OFF_CCVAL, 1, 1), 32'h0000_0000);
			wr(ca(OFF_TVAL_B, 1, 0), 32'(m * 256));
			pin_lvl[17] <= 1'b1;
			repeat (5) @(posedge aclk);
			rc("cap_rise", ca(OFF_CCVAL, 1, 1), (m == 2) ? 0 : m * 256);
			wr(ca(OFF_TVAL_B, 1, 0), 32'(m * 256 + 1));
			pin_lvl[17] <= 1'b0;
			repeat (5) @(posedge aclk);
			rc("cap_fall", ca(OFF_CCVAL, 1, 1), (m == 1) ? m * 256 : m * 256 + 1);
			rc("cap_flag", ca(OFF_CCIC, 1, 1), 32'h0000_0080);
			wr(ca(OFF_CCIC, 1, 1), 32'h0000_0000);
		end
		wr(ca(OFF_TCTRL, 0, 0), 32'h0000_0028);
		wr(ca(OFF_RLD_A, 0, 0), 32'h0000_FFFC);
		wr(ca(OFF_CCVAL, 0, 2), 32'h0000_FFFD);
		for (int m = 4; m <= 7; m++) begin
			wr(ca(OFF_MODE, 0, 2), 32'(m));
			wr(ca(OFF_TVAL_A, 0, 0), 32'h0000_FFFC);
			tick(1);
			cmp("pin_m1", 32'(m == 5 || m == 7), 32'(pin_out[2]));
			rc("flag_m1", ca(OFF_CCIC, 0, 2), 32'h0000_0080);
			wr(ca(OFF_CCIC, 0, 2), 32'h0000_0000);
			wr(ca(OFF_TVAL_A, 0, 0), 32'h0000_FFFC);
			tick(1);
			cmp("pin_m2", 32'(m == 7), 32'(pin_out[2]));
			rc("flag_m2", ca(OFF_CCIC, 0, 2), (m < 6) ? 32'h80 : 32'h0);
			wr(ca(OFF_CCIC, 0, 2), 32'h0000_0000);
			tick(3);
			cmp("pin_ovf", 32'h0000_0000, 32'(pin_out[2]));
		end
		wr(ca(OFF_MODE, 0, 2), 32'h0000_0005);
		wr(ca(OFF_CCVAL, 0, 2), 32'h0000_FFFE);
		wr(ca(OFF_MODE, 0, 10), 32'h0000_0015);
		wr(ca(OFF_CCVAL, 0, 10), 32'h0000_FFFD);
		wr(ca(OFF_TVAL_A, 0, 0), 32'h0000_FFFC);
		tick(1);
		cmp("dbl_a", 32'h0000_0001, 32'(pin_out[2]));
		tick(1);
		cmp("dbl_b", 32'h0000_0000, 32'(pin_out[2]));
		wr(ca(OFF_MODE, 1, 8), 32'h0000_0005);
		wr(ca(OFF_MODE, 1, 0), 32'h0000_0005);
		cmp("oe", 32'h0000_0001, 32'({pin_oe[24], pin_oe[16]}));
		wr(ca(OFF_TCTRL, 0, 0), 32'h0000_0030);
		wr(ca(OFF_TVAL_A, 0, 0), 32'h0000_0000);
		repeat (3) begin
			ext_in[0] <= 1'b1;
			repeat (3) @(posedge aclk);
			ext_in[0] <= 1'b0;
			repeat (3) @(posedge aclk);
		end
		repeat (4) @(posedge aclk);
		rc("ext", ca(OFF_TVAL_A, 0, 0), 32'h0000_0003);
		for (int k = 0; k < 8; k++) begin
			wr(ca(OFF_TCTRL, 0, 0), 32'h20 | 32'(k));
			wr(ca(OFF_TVAL_A, 0, 0), 32'h0000_0000);
			repeat (3 * (8 << k)) @(posedge aclk);
			rd(ca(OFF_TVAL_A, 0, 0));
			cmp("presc", 32'h0000_0001, 32'(d >= 2 && d <= 4));
		end
		end_sim();
	end
endmodule
